/* design/sts_seq.sv */
// Self-test sequencer and result word encoder.
// ==========================================================================
`include "sts_consts.svh"
module sts_seq #(
  parameter int CFG_W      = `STS_CFG_W,
  parameter int SAMPLE_DIV = 250,
  parameter int SETTLE_CYC = 2500
) (
  input  wire logic              CLK,
  input  wire logic              RST,
  input  wire logic              TEST_START,
  input  wire logic              MEM_POST_FAIL,
  input  wire logic              BUS_FAULT,
  input  wire logic              RELAY_REQ,
  input  wire logic [CFG_W-1:0]  CFG_IN,
  input  wire logic              LOOP_LOCK_INDICATOR,
  input  wire logic              MEAS_ACK,
  input  wire logic [15:0]       MEAS_VALUE,
  input  wire logic              MEAS_STABLE,
  input  wire logic              MEAS_OVER,
  output logic                   BUSY,
  output logic                   RESULT_VALID,
  output logic [15:0]            RESULT_WORD,
  output logic [7:0]             STATUS_BITS,
  output logic [CFG_W-1:0]       CFG_OUT,
  output logic                   CFG_RESTORE,
  output logic                   RELAY_CLOSE,
  output logic                   ADDR_RESET,
  output logic                   MEAS_REQ,
  output logic [2:0]             MEAS_POINT,
  output logic [3:0]             STEP_CODE,
  output logic                   SAMPLED_WAVEFORM_LOOP_MODE,
  output logic                   LOOP_DETUNE
);

  sts_pkg::sts_state_t  state_r;
  sts_pkg::sts_state_t  state_nxt;
  sts_pkg::sts_step_t   step_r;
  logic [7:0]           err_r;
  logic [7:0]           tnum_r;
  logic [3:0]           tries_r;
  logic [31:0]          wait_r;
  logic                 grp_end;
  logic                 last_step;
  logic                 lk_s1_r;
  logic                 lk_s2_r;
  logic                 lk_s3_r;
  logic                 lk_lvl_r;
  logic [CFG_W-1:0]     saved_r;
  logic                 lk_start_r;

  sts_lock_if lk_if ();

  // ==========================================================================
  // Decoding helpers
  function automatic logic [7:0] step_test(sts_pkg::sts_step_t s);
    case (s)
      sts_pkg::SP_ADC:     step_test = `STS_TN_ADC;
      sts_pkg::SP_CW_LK,
      sts_pkg::SP_CW_UNL,
      sts_pkg::SP_RS_LK,
      sts_pkg::SP_RS_UNL:  step_test = `STS_TN_SYN;
      sts_pkg::SP_OFS_POS,
      sts_pkg::SP_OFS_NEG: step_test = `STS_TN_OFS;
      default:             step_test = `STS_TN_AMP;
    endcase
  endfunction : step_test

  function automatic logic is_lock(sts_pkg::sts_step_t s);
    is_lock = (step_test(s) == `STS_TN_SYN);
  endfunction : is_lock

  function automatic logic [2:0] step_point(sts_pkg::sts_step_t s);
    case (step_test(s))
      `STS_TN_ADC: step_point = `STS_PT_ZERO;
      `STS_TN_OFS: step_point = `STS_PT_OFS;
      default:     step_point = `STS_PT_AMP;
    endcase
  endfunction : step_point

  // Readings are judged in signed units of 100 uV.
  function automatic logic [7:0] meas_bits(sts_pkg::sts_step_t s,
                                           logic signed [15:0] v);
    logic [7:0]         b;
    logic signed [15:0] m;
    b = 8'h00;
    m = (v < 0) ? -v : v;
    case (s)
      sts_pkg::SP_ADC: begin
        b[`STS_EB_ADC] = (m > $signed(`STS_ADC_LIM));
      end
      sts_pkg::SP_OFS_POS: begin
        b[`STS_EB_PLO] = (m < $signed(`STS_OFS_LO));
        b[`STS_EB_PHI] = (m > $signed(`STS_OFS_HI));
      end
      sts_pkg::SP_OFS_NEG: begin
        b[`STS_EB_NLO] = (m < $signed(`STS_OFS_LO));
        b[`STS_EB_NHI] = (m > $signed(`STS_OFS_HI));
      end
      sts_pkg::SP_AMP_MAX: begin
        b[`STS_EB_MAX_LO] = (v <= $signed(`STS_AMP_LO));
        b[`STS_EB_MAX_HI] = (v >= $signed(`STS_AMP_HI));
      end
      sts_pkg::SP_AMP_MIN: begin
        b[`STS_EB_MIN_LO] = (v < -$signed(`STS_MIN_LIM));
        b[`STS_EB_MIN_HI] = (v > $signed(`STS_MIN_LIM));
      end
      default: b = 8'h00;
    endcase
    meas_bits = b;
  endfunction : meas_bits

  function automatic logic [7:0] lock_bits(sts_pkg::sts_step_t s,
                                           logic lkd, logic unl);
    lock_bits = 8'h00;
    case (s)
      sts_pkg::SP_CW_LK:  lock_bits[`STS_EB_CW_LK]  = !lkd;
      sts_pkg::SP_CW_UNL: lock_bits[`STS_EB_CW_UNL] = !unl;
      sts_pkg::SP_RS_LK:  lock_bits[`STS_EB_RS_LK]  = !lkd;
      default:            lock_bits[`STS_EB_RS_UNL] = !unl;
    endcase
  endfunction : lock_bits

  function automatic logic [CFG_W-1:0] force_safe(logic [CFG_W-1:0] c);
    logic [CFG_W-1:0] f;
    f = c;
    f[`STS_CFG_OUT_EN]                   = 1'b0;
    f[`STS_CFG_FILT_EN]                  = 1'b0;
    f[`STS_CFG_SYNC_EN]                  = 1'b0;
    f[`STS_CFG_MCLK_EN]                  = 1'b0;
    f[`STS_CFG_ATT_HI:`STS_CFG_ATT_LO]   = `STS_ATT_DIV1;
    f[`STS_CFG_SRC]                      = `STS_SRC_WAVE;
    f[`STS_CFG_CLK_HI:`STS_CFG_CLK_LO]   = `STS_CLK_50M;
    force_safe = f;
  endfunction : force_safe

  // ==========================================================================
  // Lock indicator synchroniser
  // The pin is asynchronous; a change is taken once stages two and three
  // agree, which also rejects a single metastable settle.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      lk_s1_r  <= 1'b0;
      lk_s2_r  <= 1'b0;
      lk_s3_r  <= 1'b0;
      lk_lvl_r <= 1'b0;
    end else begin
      lk_s1_r <= LOOP_LOCK_INDICATOR;
      lk_s2_r <= lk_s1_r;
      lk_s3_r <= lk_s2_r;
      if (lk_s2_r == lk_s3_r) begin
        lk_lvl_r <= lk_s3_r;
      end
    end
  end

  assign lk_if.level = lk_lvl_r;
  assign lk_if.start = lk_start_r;

  sts_lock_chk #(
    .SAMPLE_DIV (SAMPLE_DIV)
  ) u_lock_chk (
    .CLK (CLK),
    .RST (RST),
    .lk  (lk_if.chk)
  );

  // ==========================================================================
  // Sequencer
  assign last_step = (step_r == sts_pkg::SP_AMP_MIN);
  assign grp_end   = last_step ||
                     (step_test(step_r.next()) != step_test(step_r));

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      sts_pkg::ST_IDLE: begin
        if (TEST_START) begin
          state_nxt = sts_pkg::ST_SETUP;
        end
      end
      sts_pkg::ST_SETUP: begin
        state_nxt = sts_pkg::ST_MEMCHK;
      end
      sts_pkg::ST_MEMCHK: begin
        if (MEM_POST_FAIL || BUS_FAULT) begin
          state_nxt = sts_pkg::ST_FINISH;
        end else begin
          state_nxt = sts_pkg::ST_MREQ;
        end
      end
      sts_pkg::ST_MREQ: begin
        state_nxt = sts_pkg::ST_MWAIT;
      end
      sts_pkg::ST_MWAIT: begin
        if (MEAS_ACK) begin
          if (!MEAS_STABLE && (tries_r < `STS_MAX_TRIES - 1'b1)) begin
            state_nxt = sts_pkg::ST_MREQ;
          end else begin
            state_nxt = sts_pkg::ST_NEXT;
          end
        end
      end
      sts_pkg::ST_LSETTLE: begin
        if (wait_r == 32'(SETTLE_CYC - 1)) begin
          state_nxt = sts_pkg::ST_LRUN;
        end
      end
      sts_pkg::ST_LRUN: begin
        if (lk_if.done) begin
          state_nxt = sts_pkg::ST_NEXT;
        end
      end
      sts_pkg::ST_NEXT: begin
        if (grp_end && ((err_r != 8'h00) || last_step)) begin
          state_nxt = sts_pkg::ST_FINISH;
        end else if (is_lock(step_r.next())) begin
          state_nxt = sts_pkg::ST_LSETTLE;
        end else begin
          state_nxt = sts_pkg::ST_MREQ;
        end
      end
      sts_pkg::ST_FINISH: begin
        state_nxt = sts_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = sts_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_r <= sts_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================================
  // Step, error code, test number and retry tracking
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      step_r  <= sts_pkg::SP_ADC;
      err_r   <= 8'h00;
      tnum_r  <= 8'h00;
      tries_r <= 4'h0;
    end else begin
      case (state_r)
        sts_pkg::ST_SETUP: begin
          step_r  <= sts_pkg::SP_ADC;
          err_r   <= 8'h00;
          tries_r <= 4'h0;
        end
        sts_pkg::ST_MEMCHK: begin
          tnum_r              <= `STS_TN_MEM;
          err_r[`STS_EB_MEM]  <= MEM_POST_FAIL;
          err_r[`STS_EB_BUS]  <= BUS_FAULT;
          if (!(MEM_POST_FAIL || BUS_FAULT)) begin
            tnum_r <= step_test(sts_pkg::SP_ADC);
          end
        end
        sts_pkg::ST_MWAIT: begin
          if (MEAS_ACK) begin
            tries_r <= tries_r + 1'b1;
            if (!MEAS_STABLE) begin
              if (tries_r == `STS_MAX_TRIES - 1'b1) begin
                err_r[`STS_EB_NSET] <= 1'b1;
              end
            end else if (MEAS_OVER) begin
              err_r[`STS_EB_OVR] <= 1'b1;
            end else begin
              err_r <= err_r | meas_bits(step_r, $signed(MEAS_VALUE));
            end
          end
        end
        sts_pkg::ST_LRUN: begin
          if (lk_if.done) begin
            err_r <= err_r |
                     lock_bits(step_r, lk_if.locked, lk_if.unlocked);
          end
        end
        sts_pkg::ST_NEXT: begin
          tries_r <= 4'h0;
          if (!(grp_end && ((err_r != 8'h00) || last_step))) begin
            step_r <= step_r.next();
            tnum_r <= step_test(step_r.next());
            if (grp_end) begin
              err_r <= 8'h00;
            end
          end
        end
        default: tries_r <= tries_r;
      endcase
    end
  end

  // ==========================================================================
  // Loop mode control and settle timer
  // Each loop run gets a settle interval after a mode or detune change so
  // the indicator reflects the new loop condition, not the transition.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wait_r     <= 32'h0000_0000;
      lk_start_r <= 1'b0;
    end else begin
      lk_start_r <= (state_r == sts_pkg::ST_LSETTLE) &&
                    (state_nxt == sts_pkg::ST_LRUN);
      if (state_r == sts_pkg::ST_LSETTLE) begin
        wait_r <= wait_r + 1'b1;
      end else begin
        wait_r <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      SAMPLED_WAVEFORM_LOOP_MODE <= 1'b0;
      LOOP_DETUNE                <= 1'b0;
    end else begin
      SAMPLED_WAVEFORM_LOOP_MODE <= (step_r == sts_pkg::SP_RS_LK) ||
                                    (step_r == sts_pkg::SP_RS_UNL);
      LOOP_DETUNE <= (step_r == sts_pkg::SP_CW_UNL) ||
                     (step_r == sts_pkg::SP_RS_UNL);
    end
  end

  // ==========================================================================
  // Configuration save, force and restore
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      saved_r     <= '0;
      CFG_OUT     <= '0;
      CFG_RESTORE <= 1'b0;
      ADDR_RESET  <= 1'b0;
      RELAY_CLOSE <= 1'b0;
    end else begin
      CFG_RESTORE <= (state_r == sts_pkg::ST_FINISH);
      ADDR_RESET  <= (state_r == sts_pkg::ST_SETUP);
      RELAY_CLOSE <= RELAY_REQ && (state_nxt == sts_pkg::ST_IDLE) &&
                     (state_r == sts_pkg::ST_IDLE);
      case (state_r)
        sts_pkg::ST_IDLE: begin
          CFG_OUT <= CFG_IN;
        end
        sts_pkg::ST_SETUP: begin
          saved_r <= CFG_IN;
          CFG_OUT <= force_safe(CFG_IN);
        end
        sts_pkg::ST_FINISH: begin
          CFG_OUT <= saved_r;
        end
        default: CFG_OUT <= CFG_OUT;
      endcase
    end
  end

  // ==========================================================================
  // Measurement request and result word
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      MEAS_REQ     <= 1'b0;
      MEAS_POINT   <= 3'h0;
      STEP_CODE    <= 4'h0;
      RESULT_VALID <= 1'b0;
      RESULT_WORD  <= 16'h0000;
      STATUS_BITS  <= 8'h00;
    end else begin
      MEAS_REQ   <= (state_r == sts_pkg::ST_MREQ);
      MEAS_POINT <= step_point(step_r);
      STEP_CODE  <= step_r;
      RESULT_VALID <= (state_r == sts_pkg::ST_FINISH);
      if (state_r == sts_pkg::ST_FINISH) begin
        if (err_r != 8'h00) begin
          RESULT_WORD <= {tnum_r, err_r};
        end else begin
          RESULT_WORD <= 16'h0000;
        end
      end
      STATUS_BITS                <= 8'h00;
      STATUS_BITS[`STS_ST_BUSY]  <= (state_nxt != sts_pkg::ST_IDLE);
      STATUS_BITS[`STS_ST_FAIL]  <= (RESULT_WORD != 16'h0000);
      STATUS_BITS[`STS_ST_LOCK]  <= lk_lvl_r;
    end
  end

  assign BUSY = (state_r != sts_pkg::ST_IDLE);

endmodule : sts_seq

/* design/sts_consts.svh */
// Constants for the self-test status sequencer.
`ifndef STS_CONSTS_SVH
`define STS_CONSTS_SVH

// ==========================================================================
// Configuration word layout
`define STS_CFG_W        10
`define STS_CFG_OUT_EN   0
`define STS_CFG_FILT_EN  1
`define STS_CFG_SYNC_EN  2
`define STS_CFG_MCLK_EN  3
`define STS_CFG_ATT_LO   4
`define STS_CFG_ATT_HI   5
`define STS_CFG_SRC      6
`define STS_CFG_CLK_LO   7
`define STS_CFG_CLK_HI   9
`define STS_ATT_DIV1     2'h0
`define STS_SRC_WAVE     1'h0
`define STS_CLK_50M      3'h0

// ==========================================================================
// Test numbers and error bit positions
`define STS_TN_MEM       8'h01
`define STS_TN_ADC       8'h02
`define STS_TN_SYN       8'h03
`define STS_TN_OFS       8'h04
`define STS_TN_AMP       8'h05
`define STS_EB_NSET      0
`define STS_EB_OVR       1
`define STS_EB_MEM       1
`define STS_EB_BUS       2
`define STS_EB_ADC       2
`define STS_EB_CW_LK     0
`define STS_EB_CW_UNL    1
`define STS_EB_RS_LK     2
`define STS_EB_RS_UNL    3
`define STS_EB_PLO       2
`define STS_EB_PHI       3
`define STS_EB_NLO       4
`define STS_EB_NHI       5
`define STS_EB_MAX_LO    2
`define STS_EB_MAX_HI    3
`define STS_EB_MIN_LO    4
`define STS_EB_MIN_HI    5
`define STS_ST_BUSY      0
`define STS_ST_FAIL      1
`define STS_ST_LOCK      2

// ==========================================================================
// Measurement limits, readings in units of 100 uV
`define STS_ADC_LIM      16'h0014
`define STS_OFS_LO       16'h1ED9
`define STS_OFS_HI       16'h25B4
`define STS_AMP_LO       16'h2710
`define STS_AMP_HI       16'h2EE0
`define STS_MIN_LIM      16'h0096
`define STS_MAX_TRIES    4'hA

// ==========================================================================
// Lock duty judgement
`define STS_LK_CNT_W     10
`define STS_LK_SAMPLES   10'h3E8
`define STS_LK_MAX_LOW   10'h032
`define STS_UNL_MIN_LOW  10'h190

// ==========================================================================
// Measurement point select codes
`define STS_PT_ZERO      3'h7
`define STS_PT_OFS       3'h2
`define STS_PT_AMP       3'h1

`endif

/* design/sts_pkg.sv */
// Types for the self-test status sequencer.
package sts_pkg;

  // ========================================================================
  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE, ST_SETUP, ST_MEMCHK, ST_MREQ, ST_MWAIT,
    ST_LSETTLE, ST_LRUN, ST_NEXT, ST_FINISH
  } sts_state_t;

  // ========================================================================
  // Sub-test steps, in execution order
  typedef enum logic [3:0] {
    SP_ADC, SP_CW_LK, SP_CW_UNL, SP_RS_LK, SP_RS_UNL,
    SP_OFS_POS, SP_OFS_NEG, SP_AMP_MAX, SP_AMP_MIN
  } sts_step_t;

endpackage : sts_pkg

/* design/sts_lock_if.sv */
// Carrier between the sequencer and the lock duty checker.
`include "sts_consts.svh"
interface sts_lock_if;
  logic                      start;
  logic                      level;
  logic                      done;
  logic                      locked;
  logic                      unlocked;
  logic [`STS_LK_CNT_W-1:0]  low_cnt;
  modport seq (output start, level, input done, locked, unlocked, low_cnt);
  modport chk (input start, level, output done, locked, unlocked, low_cnt);
endinterface : sts_lock_if

/* design/sts_lock_chk.sv */
// Lock duty checker: samples the lock level and counts low samples.
`include "sts_consts.svh"
module sts_lock_chk #(
  parameter int DIV_W      = 16,
  parameter int SAMPLE_DIV = 250
) (
  input wire logic   CLK,
  input wire logic   RST,
  sts_lock_if.chk    lk
);

  logic [DIV_W-1:0]          div_r;
  logic                      run_r;
  logic                      smp_en;
  logic [`STS_LK_CNT_W-1:0]  n_r;
  logic [`STS_LK_CNT_W-1:0]  low_r;
  logic [`STS_LK_CNT_W-1:0]  low_nxt;
  logic                      done_r;
  logic                      locked_r;
  logic                      unlocked_r;

  // ========================================================================
  // Sample enable divider
  assign smp_en = run_r && (div_r == DIV_W'(SAMPLE_DIV - 1));

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      div_r <= '0;
    end else if (!run_r || smp_en) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  // ========================================================================
  // Sample counting and verdict
  assign low_nxt = low_r + {{(`STS_LK_CNT_W-1){1'b0}}, ~lk.level};

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      run_r      <= 1'b0;
      n_r        <= '0;
      low_r      <= '0;
      done_r     <= 1'b0;
      locked_r   <= 1'b0;
      unlocked_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (lk.start) begin
        run_r <= 1'b1;
        n_r   <= '0;
        low_r <= '0;
      end else if (smp_en) begin
        n_r   <= n_r + 1'b1;
        low_r <= low_nxt;
        if (n_r == `STS_LK_SAMPLES - 1'b1) begin
          run_r      <= 1'b0;
          done_r     <= 1'b1;
          locked_r   <= (low_nxt < `STS_LK_MAX_LOW);
          unlocked_r <= (low_nxt > `STS_UNL_MIN_LOW);
        end
      end
    end
  end

  assign lk.done     = done_r;
  assign lk.locked   = locked_r;
  assign lk.unlocked = unlocked_r;
  assign lk.low_cnt  = low_r;

endmodule : sts_lock_chk

/* dv/sts_seq_sva.sv */
// Port-level checks for the self-test sequencer.
module sts_seq_sva #(
  parameter int CFG_W = 10
) (
  input wire logic             CLK,
  input wire logic             RST,
  input wire logic             TEST_START,
  input wire logic             MEM_POST_FAIL,
  input wire logic             BUS_FAULT,
  input wire logic [CFG_W-1:0] CFG_IN,
  input wire logic             LOOP_LOCK_INDICATOR,
  input wire logic             BUSY,
  input wire logic             RESULT_VALID,
  input wire logic [15:0]      RESULT_WORD,
  input wire logic [7:0]       STATUS_BITS,
  input wire logic [CFG_W-1:0] CFG_OUT,
  input wire logic             CFG_RESTORE,
  input wire logic             RELAY_CLOSE,
  input wire logic             ADDR_RESET,
  input wire logic             MEAS_REQ,
  input wire logic [3:0]       STEP_CODE
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  logic [CFG_W-1:0] saved_r;
  logic [3:0]       last_r;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      saved_r <= '0;
      last_r  <= 4'h0;
    end else if (TEST_START && !BUSY) begin
      saved_r <= CFG_IN;
      last_r  <= 4'h0;
    end else if (MEAS_REQ) begin
      last_r <= STEP_CODE;
    end
  end
  sequence s_start; TEST_START && !BUSY; endsequence
  sequence s_done; RESULT_VALID && !BUSY; endsequence
  relay_open_a: assert property (
    BUSY && $past(BUSY) |-> !RELAY_CLOSE)
    else $error("relays closed during self test");
  safe_cfg_a: assert property (
    s_start |-> ##2 ADDR_RESET ##0 (BUSY && CFG_OUT == '0)[*2])
    else $error("unsafe configuration during self test");
  cfg_restore_a: assert property (
    CFG_RESTORE |-> s_done ##0 CFG_OUT == saved_r)
    else $error("configuration not restored");
  fault_abort_a: assert property (
    s_start ##0 (MEM_POST_FAIL || BUS_FAULT) |-> ##4 s_done ##0
    RESULT_WORD[15:8] == 8'h01 && RESULT_WORD[2:1] == {BUS_FAULT, MEM_POST_FAIL})
    else $error("fault abort word wrong");
  field_pair_a: assert property (
    RESULT_VALID |-> (RESULT_WORD[15:8] == 8'h00) == (RESULT_WORD[7:0] == 8'h00))
    else $error("test number and error code disagree");
  test_num_a: assert property (
    RESULT_VALID |-> RESULT_WORD[15:8] <= 8'h05)
    else $error("test number out of range");
  step_order_a: assert property (
    MEAS_REQ |-> STEP_CODE >= last_r)
    else $error("steps out of order");
  lock_status_a: assert property (
    $stable(LOOP_LOCK_INDICATOR)[*6] |-> STATUS_BITS[2] == LOOP_LOCK_INDICATOR)
    else $error("lock status bit wrong");
endmodule : sts_seq_sva

bind sts_seq sts_seq_sva #(.CFG_W(CFG_W)) chk_u (
  .CLK(CLK), .RST(RST), .TEST_START(TEST_START),
  .MEM_POST_FAIL(MEM_POST_FAIL), .BUS_FAULT(BUS_FAULT), .CFG_IN(CFG_IN),
  .LOOP_LOCK_INDICATOR(LOOP_LOCK_INDICATOR), .BUSY(BUSY),
  .RESULT_VALID(RESULT_VALID), .RESULT_WORD(RESULT_WORD),
  .STATUS_BITS(STATUS_BITS), .CFG_OUT(CFG_OUT), .CFG_RESTORE(CFG_RESTORE),
  .RELAY_CLOSE(RELAY_CLOSE), .ADDR_RESET(ADDR_RESET), .MEAS_REQ(MEAS_REQ),
  .STEP_CODE(STEP_CODE)
);

/* dv/sts_far_model.sv */
// Far-side model: measurement unit and loop lock indicator.
module sts_far_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        meas_req,
  input  wire logic [3:0]  step,
  input  wire logic        detune,
  input  wire logic [3:0]  bad_step,
  input  wire logic [15:0] bad_val,
  input  wire logic [1:0]  bad_kind,
  input  wire logic [1:0]  lock_mode,
  input  wire logic [1:0]  dly,
  output logic             ack,
  output logic [15:0]      value,
  output logic             stable,
  output logic             over,
  output logic             lock_ind
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Behaviour
  logic [1:0]  wait_r;
  logic        pend_r;
  logic [5:0]  ph_r;
  logic [15:0] good;
  logic        hit;
  assign hit = step == bad_step;
  always_comb begin
    case (step)
      4'h5: good = 16'h2247;
      4'h6: good = 16'hDDB9;
      4'h7: good = 16'h2AF8;
      default: good = 16'h0000;
    endcase
  end
  // Except in lock modes 1 and 2 (held low, held high), the indicator pulses rather than holding a level, as a real loop does.
  always_comb begin
    case (lock_mode)
      2'h1: lock_ind = 1'b0;
      2'h2: lock_ind = !rst;
      default: lock_ind = !rst && (detune ? ph_r[1:0] == 2'h0 : ph_r != 6'h00);
    endcase
  end
  // Released reading toggles so a stale value cannot pass as fresh.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_r <= 1'b0;
      wait_r <= 2'h0;
      ack    <= 1'b0;
      value  <= 16'h0000;
      stable <= 1'b0;
      over   <= 1'b0;
      ph_r   <= 6'h00;
    end else begin
      ph_r  <= ph_r + 6'h01;
      ack   <= 1'b0;
      value <= ~value;
      if (meas_req) begin
        pend_r <= 1'b1;
        wait_r <= dly;
      end else if (pend_r && wait_r != 2'h0) begin
        wait_r <= wait_r - 2'h1;
      end else if (pend_r) begin
        pend_r <= 1'b0;
        ack    <= 1'b1;
        value  <= (hit && bad_kind == 2'h0) ? bad_val : good;
        stable <= !(hit && bad_kind == 2'h1);
        over   <= hit && bad_kind == 2'h2;
      end
    end
  end
endmodule : sts_far_model

/* dv/sts_seq_bench.sv */
// Self-checking bench for the self-test sequencer.
module sts_seq_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Bench
  logic        CLK, RST, TEST_START, MEM_POST_FAIL, BUS_FAULT, RELAY_REQ;
  logic        BUSY, RESULT_VALID, CFG_RESTORE, RELAY_CLOSE, ADDR_RESET;
  logic        MEAS_REQ, LOOP_DETUNE, MEAS_ACK, MEAS_STABLE, MEAS_OVER;
  logic        LOOP_LOCK_INDICATOR;
  logic [9:0]  CFG_IN, CFG_OUT;
  logic [15:0] RESULT_WORD, MEAS_VALUE, bad_val;
  logic [7:0]  STATUS_BITS;
  logic [3:0]  STEP_CODE, bad_step;
  logic [2:0]  MEAS_POINT;
  logic [1:0]  bad_kind, lock_mode, dly;
  int          fail_count, n_compared;
  sts_seq #(.SAMPLE_DIV(2), .SETTLE_CYC(4)) dut_u (
    .CLK(CLK), .RST(RST), .TEST_START(TEST_START),
    .MEM_POST_FAIL(MEM_POST_FAIL), .BUS_FAULT(BUS_FAULT),
    .RELAY_REQ(RELAY_REQ), .CFG_IN(CFG_IN),
    .LOOP_LOCK_INDICATOR(LOOP_LOCK_INDICATOR), .MEAS_ACK(MEAS_ACK),
    .MEAS_VALUE(MEAS_VALUE), .MEAS_STABLE(MEAS_STABLE),
    .MEAS_OVER(MEAS_OVER), .BUSY(BUSY), .RESULT_VALID(RESULT_VALID),
    .RESULT_WORD(RESULT_WORD), .STATUS_BITS(STATUS_BITS),
    .CFG_OUT(CFG_OUT), .CFG_RESTORE(CFG_RESTORE),
    .RELAY_CLOSE(RELAY_CLOSE), .ADDR_RESET(ADDR_RESET),
    .MEAS_REQ(MEAS_REQ), .MEAS_POINT(MEAS_POINT), .STEP_CODE(STEP_CODE),
    .SAMPLED_WAVEFORM_LOOP_MODE(), .LOOP_DETUNE(LOOP_DETUNE));
  sts_far_model far_u (
    .clk(CLK), .rst(RST), .meas_req(MEAS_REQ), .step(STEP_CODE),
    .detune(LOOP_DETUNE), .bad_step(bad_step), .bad_val(bad_val),
    .bad_kind(bad_kind), .lock_mode(lock_mode), .dly(dly),
    .ack(MEAS_ACK), .value(MEAS_VALUE), .stable(MEAS_STABLE),
    .over(MEAS_OVER), .lock_ind(LOOP_LOCK_INDICATOR));
  task automatic check(input string what, input logic [15:0] e, g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : check
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test
  // A second start while busy is sent on purpose and must be ignored.
  task automatic run(input logic [3:0] s, input logic [15:0] v,
                     input logic [1:0] k, lm, mb, output logic [15:0] w);
    int i;
    bad_step = s;
    bad_val = v;
    bad_kind = k;
    lock_mode = lm;
    {BUS_FAULT, MEM_POST_FAIL} = mb;
    CFG_IN = 10'($urandom);
    dly = 2'($urandom);
    TEST_START = 1'b1;
    @(negedge CLK);
    TEST_START = 1'b0;
    @(negedge CLK);
    TEST_START = 1'b1;
    @(negedge CLK);
    TEST_START = 1'b0;
    for (i = 0; i < 20000 && RESULT_VALID !== 1'b1; i++) @(negedge CLK);
    w = RESULT_WORD;
    check("restored cfg", 16'(CFG_IN), 16'(CFG_OUT));
    @(negedge CLK);
  endtask : run
  function automatic logic [15:0] exp_word(input logic [3:0] s,
                                           input logic signed [15:0] v);
    logic signed [15:0] m;
    m = v < 0 ? -v : v;
    case (s)
      4'h0: return m > 16'sh0014 ? 16'h0204 : 16'h0000;
      4'h5: return v < 16'sh1ED9 ? 16'h0404 : v > 16'sh25B4 ? 16'h0408 : 0;
      4'h6: return m < 16'sh1ED9 ? 16'h0410 : m > 16'sh25B4 ? 16'h0420 : 0;
      4'h7: return v <= 16'sh2710 ? 16'h0504 : v >= 16'sh2EE0 ? 16'h0508 : 0;
      default: return v < -16'sh0096 ? 16'h0510 : v > 16'sh0096 ? 16'h0520 : 0;
    endcase
  endfunction : exp_word
  logic [3:0]  cs [9] = '{4'h0, 4'h6, 4'h7, 4'h8, 4'h0, 4'h5, 4'h6, 4'h7, 4'h8};
  logic [15:0] cv [4] = '{16'h0015, 16'hE128, 16'h2EE0, 16'hFF69};
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  initial begin
    repeat (32'h0001_7318) @(posedge CLK);
    fail_count++;
    finish_test();
  end
  initial begin
    logic [15:0] w;
    logic signed [15:0] v;
    logic [3:0] s;
    {TEST_START, MEM_POST_FAIL, BUS_FAULT, CFG_IN, dly} = '0;
    {bad_val, bad_kind, lock_mode} = '0;
    bad_step = 4'hF;
    RELAY_REQ = 1'b1;
    RST = 1'b1;
    void'($urandom(63202));
    repeat (8) @(negedge CLK);
    RST = 1'b0;
    run(4'hF, 16'h0000, 2'h0, 2'h0, 2'h0, w);
    check("pass word", 16'h0000, w);
    for (int k = 1; k < 4; k++) begin
      run(4'hF, 16'h0000, 2'h0, 2'h0, 2'(k), w);
      check("abort word", {8'h01, 5'h00, 2'(k), 1'b0}, w);
    end
    run(4'hF, 16'h0000, 2'h0, 2'h1, 2'h0, w);
    check("stuck low", 16'h0305, w);
    run(4'hF, 16'h0000, 2'h0, 2'h2, 2'h0, w);
    check("stuck high", 16'h030A, w);
    for (int k = 1; k < 3; k++) begin
      run(4'h0, 16'h0000, 2'(k), 2'h0, 2'h0, w);
      check("reading flags", {14'h0080, 2'(k)}, w);
    end
    for (int k = 0; k < 7; k++) begin
      s = k < 4 ? cs[k] : cs[4 + $urandom_range(4)];
      v = k < 4 ? cv[k] : 16'($urandom_range(32'h0000_5DC0) - 32'h0000_2EE0);
      if (k >= 4 && s == 4'h5 && v < 0) v = -v;
      if (k >= 4 && s == 4'h6 && v > 0) v = -v;
      run(s, v, 2'h0, 2'h0, 2'h0, w);
      check("fail word", exp_word(s, v), w);
    end
    finish_test();
  end
endmodule : sts_seq_bench
